// [rtl/poc_operational_cmd.sv]
`timescale 1ns/10ps

// One controller: request, in-service and priority state with its command words
module poc_ctl (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Command port
  input wire logic sel_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  // Interrupt side
  input wire logic [7:0] req_i,
  input wire logic [7:0] trig_i,
  input wire logic [7:0] mask_i,
  input wire logic auto_end_i,
  input wire logic ack_i,
  // Results
  output logic intr_o,
  output logic [2:0] win_lvl_o,
  output logic [7:0] rbyte_o
);
  logic [7:0] req_reg;
  logic [7:0] svc_reg;
  logic [7:0] req_q;
  logic [2:0] lowest;
  logic rot_auto;
  logic spec_mask;
  logic read_svc;
  logic poll_pend;
  logic [3:0] req_pick;
  logic [3:0] svc_pick;
  logic [3:0] top_svc;
  logic [2:0] req_rank;
  logic [2:0] svc_rank;
  logic [2:0] code;
  logic [2:0] lvl;
  logic cmd_wr;
  logic init_wr;
  logic prio_wr;
  logic mpoll_wr;
  logic poll_rd;
  logic take;
  logic [7:0] rise;
  logic [7:0] req_clr;
  logic [7:0] svc_clr;
  logic [7:0] svc_set;

  assign cmd_wr = sel_i & wr_i;
  assign init_wr = cmd_wr & wdata_i[poc_pkg::SEL_HI];
  assign prio_wr = cmd_wr & (wdata_i[poc_pkg::SEL_HI:poc_pkg::SEL_LO] == poc_pkg::SEL_PRIORITY);
  assign mpoll_wr = cmd_wr & (wdata_i[poc_pkg::SEL_HI:poc_pkg::SEL_LO] == poc_pkg::SEL_MASK_POLL);
  assign code = wdata_i[poc_pkg::CODE_HI:poc_pkg::CODE_LO];
  assign lvl = wdata_i[poc_pkg::LVL_HI:poc_pkg::LVL_LO];
  assign poll_rd = sel_i & rd_i & poll_pend;
  assign take = (ack_i | poll_rd) & intr_o;

  // Masked in-service levels stop blocking lower ones in special mask mode
  assign req_pick = poc_pkg::poc_pick(req_reg & ~mask_i & ~svc_reg, lowest);
  assign svc_pick = poc_pkg::poc_pick(spec_mask ? (svc_reg & ~mask_i) : svc_reg, lowest);
  assign top_svc = poc_pkg::poc_pick(svc_reg, lowest);
  assign req_rank = 3'(req_pick[2:0] - lowest - 3'h1);
  assign svc_rank = 3'(svc_pick[2:0] - lowest - 3'h1);
  assign intr_o = req_pick[3] & (~svc_pick[3] | (req_rank < svc_rank));
  assign win_lvl_o = req_pick[2:0];

  assign rise = req_i & ~req_q;
  assign req_clr = take ? (8'h01 << req_pick[2:0]) : 8'h00;
  assign svc_set = (take & ~auto_end_i) ? (8'h01 << req_pick[2:0]) : 8'h00;

  // End of service: highest in-service level, or the selected one
  always_comb begin
    svc_clr = 8'h00;
    if (prio_wr) begin
      case (code)
        poc_pkg::CMD_NS_END, poc_pkg::CMD_ROT_NS_END: svc_clr = top_svc[3] ? (8'h01 << top_svc[2:0]) : 8'h00;
        poc_pkg::CMD_SP_END, poc_pkg::CMD_ROT_SP_END: svc_clr = 8'h01 << lvl;
        default: svc_clr = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= 8'h00;
    end else begin
      req_q <= req_i;
    end
  end

  // Edge bits latch a rise, which wins over a same-cycle acknowledge; level bits follow the pin
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_reg <= 8'h00;
    end else begin
      req_reg <= (trig_i & req_i) | (~trig_i & ((req_reg & ~req_clr) | rise));
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      svc_reg <= 8'h00;
    end else if (init_wr) begin
      svc_reg <= 8'h00;
    end else begin
      svc_reg <= (svc_reg & ~svc_clr) | svc_set;
    end
  end

  // Priority base and rotation modes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lowest <= poc_pkg::LOWEST_RST;
      rot_auto <= 1'b0;
    end else if (init_wr) begin
      lowest <= poc_pkg::LOWEST_RST;
      rot_auto <= 1'b0;
    end else if (prio_wr) begin
      case (code)
        poc_pkg::CMD_ROT_AUTO_CLR: rot_auto <= 1'b0;
        poc_pkg::CMD_ROT_AUTO_SET: rot_auto <= 1'b1;
        poc_pkg::CMD_ROT_NS_END: begin
          if (top_svc[3]) begin
            lowest <= top_svc[2:0];
          end
        end
        poc_pkg::CMD_SET_PRIO, poc_pkg::CMD_ROT_SP_END: lowest <= lvl;
        default: lowest <= lowest;
      endcase
    end else if (take & auto_end_i & rot_auto) begin
      lowest <= req_pick[2:0];
    end
  end

  // Special mask mode
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spec_mask <= 1'b0;
    end else if (init_wr) begin
      spec_mask <= 1'b0;
    end else if (mpoll_wr & wdata_i[poc_pkg::SPEC_MASK_EN_BIT]) begin
      spec_mask <= wdata_i[poc_pkg::SPEC_MASK_BIT];
    end
  end

  // Read selection holds until rewritten
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_svc <= 1'b0;
    end else if (init_wr) begin
      read_svc <= 1'b0;
    end else if (mpoll_wr & wdata_i[poc_pkg::RSEL_HI]) begin
      read_svc <= wdata_i[poc_pkg::RSEL_LO];
    end
  end

  // A poll arms exactly one following read
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      poll_pend <= 1'b0;
    end else if (init_wr) begin
      poll_pend <= 1'b0;
    end else if (mpoll_wr) begin
      poll_pend <= wdata_i[poc_pkg::POLL_BIT];
    end else if (poll_rd) begin
      poll_pend <= 1'b0;
    end
  end

  always_comb begin
    if (poll_pend) begin
      rbyte_o = {intr_o, 4'h0, req_pick[2:0]};
    end else if (read_svc) begin
      rbyte_o = svc_reg;
    end else begin
      rbyte_o = req_reg;
    end
  end

endmodule : poc_ctl

module poc_operational_cmd (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Processor I/O cycle
  input wire poc_pkg::poc_io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // Interrupt request pins, levels 0-15; pin 2 is unused because master input 2 carries the slave
  input wire logic [15:0] irq_i,
  // From the mask, init and slave trigger logic
  input wire logic [15:0] mask_i,
  input wire logic [7:0] slave_trig_i,
  input wire logic auto_end_i,
  // Processor acknowledge
  input wire logic inta_i,
  output logic intr_o,
  output logic [3:0] ack_level_o
);
  logic [15:0] irq_s1;
  logic [15:0] irq_s2;
  logic [7:0] trigger;
  logic m_sel;
  logic s_sel;
  logic t_sel;
  logic s_intr;
  logic [2:0] m_lvl;
  logic [2:0] s_lvl;
  logic [7:0] m_rbyte;
  logic [7:0] s_rbyte;
  logic m_cascade;

  // Pins are asynchronous to the bus clock
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_s1 <= 16'h0000;
      irq_s2 <= 16'h0000;
    end else begin
      irq_s1 <= irq_i;
      irq_s2 <= irq_s1;
    end
  end

  assign m_sel = io_req_i.addr == poc_pkg::MASTER_CMD_ADDR;
  assign s_sel = io_req_i.addr == poc_pkg::SLAVE_CMD_ADDR;
  assign t_sel = io_req_i.addr == poc_pkg::MASTER_TRIGGER_ADDR;
  assign m_cascade = m_lvl == 3'(poc_pkg::CASCADE_LVL);

  // Reserved low bits are forced to zero so those inputs never go level
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trigger <= poc_pkg::TRIGGER_RST;
    end else if (t_sel & io_req_i.wr) begin
      trigger <= io_req_i.wdata & poc_pkg::TRIGGER_WMASK;
    end
  end

  // Slave output enters as master input 2, so master mask bit 2 blocks it
  poc_ctl u_master (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .sel_i(m_sel),
    .wr_i(io_req_i.wr),
    .rd_i(io_req_i.rd),
    .wdata_i(io_req_i.wdata),
    .req_i({irq_s2[7:3], s_intr, irq_s2[1:0]}),
    .trig_i(trigger),
    .mask_i(mask_i[7:0]),
    .auto_end_i(auto_end_i),
    .ack_i(inta_i),
    .intr_o(intr_o),
    .win_lvl_o(m_lvl),
    .rbyte_o(m_rbyte)
  );

  poc_ctl u_slave (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .sel_i(s_sel),
    .wr_i(io_req_i.wr),
    .rd_i(io_req_i.rd),
    .wdata_i(io_req_i.wdata),
    .req_i(irq_s2[15:8]),
    .trig_i(slave_trig_i),
    .mask_i(mask_i[15:8]),
    .auto_end_i(auto_end_i),
    .ack_i(inta_i & m_cascade),
    .intr_o(s_intr),
    .win_lvl_o(s_lvl),
    .rbyte_o(s_rbyte)
  );

  // Read data registered; unmapped reads give no valid, and data rests at zero between reads
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_rdata_o <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= io_req_i.rd & (m_sel | s_sel | t_sel);
      if (io_req_i.rd & m_sel) begin
        io_rdata_o <= m_rbyte;
      end else if (io_req_i.rd & s_sel) begin
        io_rdata_o <= s_rbyte;
      end else if (io_req_i.rd & t_sel) begin
        io_rdata_o <= trigger;
      end else begin
        io_rdata_o <= 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_level_o <= 4'h0;
    end else if (inta_i & intr_o) begin
      ack_level_o <= m_cascade ? {1'b1, s_lvl} : {1'b0, m_lvl};
    end
  end

endmodule : poc_operational_cmd

// [rtl/poc_pkg.sv]
package poc_pkg;

  // I/O map of the two controllers and the trigger register
  localparam logic [15:0] MASTER_CMD_ADDR = 16'h0020;
  localparam logic [15:0] SLAVE_CMD_ADDR = 16'h00a0;
  localparam logic [15:0] MASTER_TRIGGER_ADDR = 16'h04d0;

  // Field positions of the shared command port
  localparam int CODE_HI = 7;
  localparam int CODE_LO = 5;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 3;
  localparam int SPEC_MASK_BIT = 6;
  localparam int SPEC_MASK_EN_BIT = 5;
  localparam int POLL_BIT = 2;
  localparam int RSEL_HI = 1;
  localparam int RSEL_LO = 0;
  localparam int LVL_HI = 2;
  localparam int LVL_LO = 0;

  // Port selector codes
  localparam logic [1:0] SEL_PRIORITY = 2'h0;
  localparam logic [1:0] SEL_MASK_POLL = 2'h1;

  // Priority command codes
  localparam logic [2:0] CMD_ROT_AUTO_CLR = 3'h0;
  localparam logic [2:0] CMD_NS_END = 3'h1;
  localparam logic [2:0] CMD_NOP = 3'h2;
  localparam logic [2:0] CMD_SP_END = 3'h3;
  localparam logic [2:0] CMD_ROT_AUTO_SET = 3'h4;
  localparam logic [2:0] CMD_ROT_NS_END = 3'h5;
  localparam logic [2:0] CMD_SET_PRIO = 3'h6;
  localparam logic [2:0] CMD_ROT_SP_END = 3'h7;

  // Reset values, the trigger write mask and the cascade input level
  localparam logic [2:0] LOWEST_RST = 3'h7;
  localparam logic [7:0] TRIGGER_RST = 8'h00;
  localparam logic [7:0] TRIGGER_WMASK = 8'hf8;
  localparam int CASCADE_LVL = 2;

  // One processor I/O cycle
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } poc_io_req_t;

  // Highest-priority set bit of v, with the given level lowest; {found, level}
  function automatic logic [3:0] poc_pick(input logic [7:0] v, input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] k;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      k = 3'(low + 3'(i) + 3'h1);
      if (v[k]) begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction : poc_pick

endpackage : poc_pkg

// [verif/poc_host.sv]
`timescale 1ns/10ps
module poc_host (
  // Clock
  input wire logic ref_clk_i,
  // I/O cycle
  output poc_pkg::poc_io_req_t io_req_o,
  input wire logic [7:0] io_rdata_i,
  input wire logic io_rvalid_i
);
  initial io_req_o = '0;
  // Command words only written, never read back; reserved trigger bits sent as given
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    io_req_o <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge ref_clk_i);
    io_req_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : wr
  // Selection is not rewritten before each status read; the last one written still holds
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk_i);
    io_req_o <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge ref_clk_i);
    io_req_o <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    #1;
    v = io_rvalid_i;
    d = io_rdata_i;
  endtask : rd
endmodule : poc_host

// [verif/poc_op_properties.sv]
`timescale 1ns/10ps
module poc_op_properties (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Processor I/O cycle
  input wire poc_pkg::poc_io_req_t io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rvalid_o,
  // Interrupt side
  input wire logic [15:0] mask_i,
  input wire logic inta_i,
  input wire logic intr_o,
  input wire logic [3:0] ack_level_o
);
  logic rd_map;
  logic rd_trig;
  logic [7:0] trig_copy;
  assign rd_trig = io_req_i.rd && io_req_i.addr == poc_pkg::MASTER_TRIGGER_ADDR;
  assign rd_map = rd_trig || (io_req_i.rd && (io_req_i.addr == poc_pkg::MASTER_CMD_ADDR ||
                  io_req_i.addr == poc_pkg::SLAVE_CMD_ADDR));
  // Shadow of the trigger register, reserved bits dropped
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_copy <= poc_pkg::TRIGGER_RST;
    end else if (io_req_i.wr && io_req_i.addr == poc_pkg::MASTER_TRIGGER_ADDR) begin
      trig_copy <= io_req_i.wdata & poc_pkg::TRIGGER_WMASK;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_read_answered: assert property (rd_map |=> io_rvalid_o) else $error("read not answered");
  a_no_stray_answer: assert property (!rd_map |=> !io_rvalid_o) else $error("stray read answer");
  a_idle_data_zero: assert property (!io_rvalid_o |-> io_rdata_o == 8'h00) else $error("idle data");
  a_trig_readback: assert property (rd_trig |=> io_rdata_o == $past(trig_copy)) else $error("trigger read");
  a_trig_reserved: assert property (rd_trig |=> io_rdata_o[2:0] == 3'h0) else $error("reserved bits");
  a_ack_level_held: assert property (!(inta_i && intr_o) |=> $stable(ack_level_o)) else $error("ack moved");
  a_ack_not_cascade: assert property (inta_i && intr_o |=> ack_level_o != 4'h2) else $error("cascade ack");
  a_masked_quiet: assert property ((&mask_i[7:0]) |-> !intr_o) else $error("masked request");
  c_ack: cover property (inta_i && intr_o);
  c_trig_read: cover property (rd_trig);
  c_poll_hit: cover property (io_rvalid_o && io_rdata_o[7]);
endmodule : poc_op_properties

bind poc_operational_cmd poc_op_properties u_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .io_req_i(io_req_i),
  .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .mask_i(mask_i), .inta_i(inta_i), .intr_o(intr_o),
  .ack_level_o(ack_level_o));

// [verif/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic clk, rst, rvalid, inta, intr, auto_end;
  logic [7:0] rdata;
  logic [15:0] irq, mask;
  logic [3:0] ackl;
  poc_pkg::poc_io_req_t req;
  int err_total = 0;
  int checks = 0;
  poc_host host (.ref_clk_i(clk), .io_req_o(req), .io_rdata_i(rdata), .io_rvalid_i(rvalid));
  poc_operational_cmd DUT (.ref_clk_i(clk), .rst_i(rst), .io_req_i(req), .io_rdata_o(rdata), .io_rvalid_o(rvalid),
    .irq_i(irq), .mask_i(mask), .slave_trig_i(8'h00), .auto_end_i(auto_end), .inta_i(inta), .intr_o(intr),
    .ack_level_o(ackl));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rdchk(input string n, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk({n, " valid"}, 8'h01, {7'h0, v});
    chk(n, e, d);
  endtask : rdchk
  task irq_set(input logic [15:0] v);
    @(posedge clk) irq <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask : irq_set
  task ack(input logic [3:0] e);
    #1 chk("intr", 8'h01, {7'h0, intr});
    @(posedge clk) inta <= 1'b1;
    @(posedge clk) inta <= 1'b0;
    #1 chk("ack level", {4'h0, e}, {4'h0, ackl});
  endtask : ack
  task t_defaults;
    logic [7:0] d;
    logic v;
    rdchk("request reg", 16'h0020, 8'h00);
    rdchk("trigger", 16'h04d0, 8'h00);
    host.rd(16'h0030, d, v);
    chk("unmapped valid", 8'h00, {7'h0, v});
    host.wr(16'h04d0, 8'hff);
    rdchk("trigger", 16'h04d0, 8'hf8);
    host.wr(16'h04d0, 8'h00);
    $display("test defaults done");
  endtask : t_defaults
  task t_nested;
    irq_set(16'h0048);
    rdchk("request reg", 16'h0020, 8'h48);
    ack(4'h3);
    host.wr(16'h0020, 8'h0b);
    rdchk("service reg", 16'h0020, 8'h08);
    host.wr(16'h0020, 8'h20);
    ack(4'h6);
    rdchk("service reg", 16'h0020, 8'h40);
    host.wr(16'h0020, 8'h45);
    rdchk("service reg", 16'h0020, 8'h40);
    host.wr(16'h0020, 8'h66);
    rdchk("service reg", 16'h0020, 8'h00);
    irq_set(16'h0000);
    $display("test nested done");
  endtask : t_nested
  task t_rotate;
    host.wr(16'h0020, 8'h80);
    host.wr(16'h0020, 8'h00);
    host.wr(16'h0020, 8'hc4);
    irq_set(16'h0028);
    ack(4'h5);
    host.wr(16'h0020, 8'he5);
    ack(4'h3);
    host.wr(16'h0020, 8'ha0);
    host.wr(16'h0020, 8'h0b);
    rdchk("service reg", 16'h0020, 8'h00);
    irq_set(16'h0011);
    host.wr(16'h0020, 8'h10);
    rdchk("request reg", 16'h0020, 8'h11);
    ack(4'h0);
    host.wr(16'h0020, 8'h20);
    ack(4'h4);
    host.wr(16'h0020, 8'h20);
    irq_set(16'h0000);
    $display("test rotate done");
  endtask : t_rotate
  task t_special;
    irq_set(16'h000a);
    ack(4'h1);
    chk("intr", 8'h00, {7'h0, intr});
    @(posedge clk) mask <= 16'h0002;
    host.wr(16'h0020, 8'h68);
    #1 chk("intr", 8'h01, {7'h0, intr});
    host.wr(16'h0020, 8'h08);
    #1 chk("intr", 8'h01, {7'h0, intr});
    host.wr(16'h0020, 8'h28);
    #1 chk("intr", 8'h00, {7'h0, intr});
    @(posedge clk) mask <= 16'h0000;
    host.wr(16'h0020, 8'h20);
    ack(4'h3);
    host.wr(16'h0020, 8'h20);
    irq_set(16'h0000);
    $display("test special mask done");
  endtask : t_special
  task t_auto_rotate;
    @(posedge clk) auto_end <= 1'b1;
    host.wr(16'h0020, 8'h80);
    irq_set(16'h0008);
    ack(4'h3);
    irq_set(16'h0012);
    ack(4'h4);
    host.wr(16'h0020, 8'h00);
    ack(4'h1);
    irq_set(16'h0000);
    @(posedge clk) auto_end <= 1'b0;
    $display("test auto rotate done");
  endtask : t_auto_rotate
  task t_slave_poll;
    @(posedge clk) mask <= 16'h0004;
    irq_set(16'h0400);
    chk("intr", 8'h00, {7'h0, intr});
    @(posedge clk) mask <= 16'h0000;
    host.wr(16'h0020, 8'h0c);
    rdchk("poll byte", 16'h0020, 8'h82);
    @(posedge clk) mask <= 16'hffff;
    irq_set(16'h0000);
    @(posedge clk) mask <= 16'h0000;
    $display("test slave poll done");
  endtask : t_slave_poll
  task summarize;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  initial begin
    rst = 1;
    irq = '0;
    mask = '0;
    inta = 0;
    auto_end = 0;
    repeat (5) @(posedge clk);
    rst <= 0;
    t_defaults();
    t_nested();
    t_rotate();
    t_special();
    t_auto_rotate();
    t_slave_poll();
    summarize();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    summarize();
  end
endmodule : testbench
